// >>> logic/rmcc_top.v
// run-mode clock configuration register with gating-set selection and divisor logic
`include "rmcc_map.vh"

module rmcc_top (
  // clock and reset
  input wire mclk_i,
  input wire reset_n_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  // power mode and gating sets, same clock domain
  input wire [1:0] power_mode_i,
  input wire [31:0] run_gating_set_i,
  input wire [31:0] sleep_gating_set_i,
  input wire [31:0] deep_sleep_gating_set_i,
  // clock control results
  output reg [31:0] periph_clk_en_o,
  output reg [4:0] sys_divisor_o,
  output reg use_divider_o
);

  // writable-bit mask of the configuration word; reserved bits read as zero
  localparam [31:0] WR_MASK = `RMCC_RCFG_WMASK;

  // stored configuration word and its next value
  reg [31:0] rcfg_r;
  reg [31:0] rcfg_nxt;

  // selected gating word, registered into the peripheral enables
  reg [31:0] gate_nxt;

  // next values of the registered bus outputs
  reg [31:0] rdata_nxt;
  reg ack_nxt;

  // next values of the registered divider outputs
  reg [4:0] div_nxt;
  reg usediv_nxt;

  // decoded bus request
  wire req;
  wire hit;
  wire take;
  wire take_wr;

  // decoded configuration fields
  wire gate_sel;
  wire pll_on;
  wire [3:0] div_code;
  wire [3:0] eff_code;

  // byte-lane merge of write data; read-only bits keep their stored value
  function [31:0] rmcc_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer k;
    begin
      rmcc_merge = old_v;
      for (k = 0; k < `RMCC_GATE_W; k = k + 1) begin
        if (sel[k / `RMCC_LANE_W] && WR_MASK[k]) begin
          rmcc_merge[k] = new_v[k];
        end
      end
    end
  endfunction

  // clamp a divisor code to the fastest code legal for the current source
  function [3:0] rmcc_clamp;
    input [3:0] code;
    input pll;
    begin
      if (pll && (code < `RMCC_PLL_MIN_CODE)) begin
        rmcc_clamp = `RMCC_PLL_MIN_CODE;
      end else begin
        rmcc_clamp = code;
      end
    end
  endfunction

  // divisor from a code: code plus one; the reserved code 0 gives divide by one
  function [4:0] rmcc_divisor;
    input [3:0] code;
    begin
      if (code == `RMCC_CODE_RSVD) begin
        rmcc_divisor = `RMCC_DIV_ONE;
      end else begin
        rmcc_divisor = {1'b0, code} + `RMCC_DIV_ONE;
      end
    end
  endfunction

  // read-back word: stored bits with the clamped divisor code in its field
  function [31:0] rmcc_readback;
    input [31:0] cfg;
    input [3:0] code;
    begin
      rmcc_readback = cfg;
      rmcc_readback[`RMCC_DIV_HI:`RMCC_DIV_LO] = code;
    end
  endfunction

  // a request is taken only while ack is low, so each one gets one ack
  assign req = wb_cyc_i && wb_stb_i;
  assign hit = (wb_adr_i == `RMCC_OFS_RCFG);
  assign take = req && hit && !wb_ack_o;
  assign take_wr = take && wb_we_i;

  // unmapped addresses answer with err so a stray pointer is visible
  assign wb_err_o = req && !hit && !wb_ack_o;

  // field decode of the stored word
  assign gate_sel = rcfg_r[`RMCC_BIT_GATE];
  assign pll_on = !rcfg_r[`RMCC_BIT_BYPASS];
  assign div_code = rcfg_r[`RMCC_DIV_HI:`RMCC_DIV_LO];

  // the stored code is kept; only what is read and used is clamped,
  // so software that later bypasses the pll gets back its own code
  assign eff_code = rmcc_clamp(div_code, pll_on);

  // register write path
  always @* begin
    rcfg_nxt = rcfg_r;
    if (take_wr) begin
      rcfg_nxt = rmcc_merge(rcfg_r, wb_dat_i, wb_sel_i);
    end
  end

  // bus answer: ack one cycle after the take, data valid with it
  always @* begin
    ack_nxt = take;
    rdata_nxt = `RMCC_WORD_ZERO;
    if (take) begin
      rdata_nxt = rmcc_readback(rcfg_r, eff_code);
    end
  end

  // gating-set selection by power mode
  always @* begin
    gate_nxt = run_gating_set_i;
    if (gate_sel) begin
      case (power_mode_i)
        `RMCC_MODE_SLEEP: gate_nxt = sleep_gating_set_i;
        `RMCC_MODE_DEEP: gate_nxt = deep_sleep_gating_set_i;
        default: gate_nxt = run_gating_set_i;
      endcase
    end
  end

  // divider outputs follow the stored word one cycle late
  always @* begin
    // code 0 is reserved; divide by one rather than stall the clock
    div_nxt = rmcc_divisor(eff_code);
    // the pll cannot feed the system clock undivided
    usediv_nxt = rcfg_r[`RMCC_BIT_USEDIV] | pll_on;
  end

  // configuration word
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rcfg_r <= `RMCC_RCFG_RESET;
    end else begin
      rcfg_r <= rcfg_nxt;
    end
  end

  // bus outputs; ack drops the cycle after it is given
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `RMCC_WORD_ZERO;
    end else begin
      wb_ack_o <= ack_nxt;
      wb_dat_o <= rdata_nxt;
    end
  end

  // peripheral clock enables; all clocks stay off while reset is held
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_clk_en_o <= `RMCC_GATE_RESET;
    end else begin
      periph_clk_en_o <= gate_nxt;
    end
  end

  // divider outputs; the reset divisor matches the reset code
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_divisor_o <= `RMCC_DIV_RESET;
      use_divider_o <= 1'b0;
    end else begin
      sys_divisor_o <= div_nxt;
      use_divider_o <= usediv_nxt;
    end
  end

  // limitation: the divisor output is a setting only; the block that divides
  // the clock must itself avoid glitches when the divisor changes mid-period

  // limitation: power mode 3 is not a documented mode and is treated as run,
  // which keeps every peripheral that run mode enables clocked

  // trade-off: the gating word is registered, costing one cycle of delay
  // on a mode change, so that the enables leave the block glitch-free

  // trade-off: the clamp sits in front of both the read data and the divider
  // so that what software reads is always what the clock tree uses

endmodule // rmcc_top

// >>> logic/rmcc_map.vh
// register offsets, field positions and reset values of the run-mode clock configuration block
`ifndef RMCC_MAP_VH
`define RMCC_MAP_VH
`define RMCC_OFS_RCFG 8'h60
`define RMCC_RCFG_RESET 32'h078E3AC0
`define RMCC_RCFG_WMASK 32'h0FDE3FFC
`define RMCC_LANE_W 8
`define RMCC_DIV_RESET 5'h10
`define RMCC_DIV_ONE 5'h01
`define RMCC_WORD_ZERO 32'h00000000
`define RMCC_GATE_RESET 32'h00000000
`define RMCC_BIT_GATE 27
`define RMCC_DIV_HI 26
`define RMCC_DIV_LO 23
`define RMCC_BIT_USEDIV 22
`define RMCC_BIT_BYPASS 11
`define RMCC_CODE_RSVD 4'h0
`define RMCC_PLL_MIN_CODE 4'h3
`define RMCC_MODE_RUN 2'h0
`define RMCC_MODE_SLEEP 2'h1
`define RMCC_MODE_DEEP 2'h2
`define RMCC_GATE_W 32
`endif

// >>> verif/rmcc_checker.sv
// port assertions for the run-mode clock configuration block
module rmcc_checker (
  input wire mclk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i, run_gating_set_i, sleep_gating_set_i,
  input wire [31:0] deep_sleep_gating_set_i, periph_clk_en_o,
  input wire [1:0] power_mode_i,
  input wire [4:0] sys_divisor_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of the gate select; trusted only once cyc has dropped
  reg g_r;
  always @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i) g_r <= 1'h0;
    else if (wb_ack_o && wb_we_i) g_r <= wb_dat_i[27];
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && wb_adr_i == 8'h60 && !wb_ack_o
    |=> wb_ack_o)
    else $error("no ack");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_err_unmapped: assert property (wb_cyc_i && wb_stb_i && wb_adr_i != 8'h60 |-> wb_err_o)
    else $error("err");
  a_div_nonzero: assert property (sys_divisor_o != 5'h0) else $error("div zero");
  a_run_set: assert property (power_mode_i[0] == power_mode_i[1] |=>
    periph_clk_en_o == $past(run_gating_set_i)) else $error("run set");
  a_sleep_set: assert property (!wb_cyc_i && g_r && power_mode_i == 2'h1 |=>
    periph_clk_en_o == $past(sleep_gating_set_i)) else $error("sleep set");
  a_deep_set: assert property (!wb_cyc_i && g_r && power_mode_i == 2'h2 |=>
    periph_clk_en_o == $past(deep_sleep_gating_set_i)) else $error("deep set");
  a_gate_off: assert property (!wb_cyc_i && !g_r && power_mode_i != 2'h0 |=>
    periph_clk_en_o == $past(run_gating_set_i)) else $error("gate off");
endmodule // rmcc_checker
bind rmcc_top rmcc_checker i_rmcc_checker (.*);

// >>> verif/rmcc_top_tb_top.sv
// self-checking bench for the run-mode clock configuration block
module rmcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg mclk_i = 0, reset_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [7:0] wb_adr_i = 8'h60;
  reg [3:0] wb_sel_i = 4'hF;
  reg [1:0] power_mode_i = 2'h0;
  reg [31:0] wb_dat_i = 0, q, run_gating_set_i = 32'hA5, sleep_gating_set_i = 32'h5A;
  reg [31:0] deep_sleep_gating_set_i = 32'hC3;
  wire [31:0] wb_dat_o, periph_clk_en_o;
  wire [4:0] sys_divisor_o;
  wire wb_ack_o, wb_err_o, use_divider_o;
  integer n_mismatch = 0, compares = 0, cyc_n = 0;
  rmcc_top i_rmcc_top (.*);
  initial forever #2 mclk_i = ~mclk_i;
  // a hang counts as a mismatch
  always @(posedge mclk_i) if (cyc_n++ == 3000) begin
    n_mismatch++;
    close_out;
  end
  task chk(input [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  // wishbone single cycle, held until ack is sampled
  task acc(input w, input [31:0] d);
    @(posedge mclk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_dat_i} <= {2'h3, w, d};
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge mclk_i);
  endtask
  task modes(input [31:0] s, d);
    for (int m = 0; m < 4; m++) begin
      power_mode_i <= 2'(m);
      repeat (3) @(posedge mclk_i);
      chk(periph_clk_en_o, m == 1 ? s : m == 2 ? d : run_gating_set_i);
    end
  endtask
  task t_cfg(input [31:0] w, r, input [5:0] o, input [31:0] s, d);
    acc(1, w);
    acc(0, 32'h0);
    chk(q, r);
    chk({sys_divisor_o, use_divider_o}, o);
    modes(s, d);
    $display("config test done");
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    chk({sys_divisor_o, use_divider_o}, 6'h20);
    acc(0, 32'h0);
    chk(q, 32'h078E_3AC0);
    t_cfg(32'h0900_0000, 32'h0980_0000, 6'h09, sleep_gating_set_i, deep_sleep_gating_set_i);
    t_cfg(32'h0000_0800, 32'h0000_0800, 6'h02, run_gating_set_i, run_gating_set_i);
    t_cfg(32'hFFFF_FFFF, 32'h0FDE_3FFC, 6'h21, sleep_gating_set_i, deep_sleep_gating_set_i);
    {wb_cyc_i, wb_stb_i, wb_adr_i} <= {2'h3, 8'h64};
    repeat (2) @(posedge mclk_i);
    chk({wb_err_o, wb_ack_o}, 2'h2);
    close_out;
  end
  task close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule // rmcc_top_tb_top
